// ---- hw/sff_pkg.sv ----
package sff_pkg;

    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int LANES      = 4;
    localparam int ADDR_W     = 22;
    localparam int PAGE_BYTES = 256;
    localparam int SEC_PAGES  = 3;

    // erase spans in bytes
    localparam int ERASE_4K_BYTES  = 4096;
    localparam int ERASE_32K_BYTES = 32768;
    localparam int ERASE_64K_BYTES = 65536;

    // reset and idle values, lane enable masks, shift counter loads and limits
    localparam logic       CS_IDLE     = 1'b1;
    localparam logic [7:0] BYTE_RST    = 8'h00;
    localparam logic [3:0] LANE_OFF    = 4'h0;
    localparam logic [3:0] OE_SINGLE   = 4'h2;
    localparam logic [3:0] OE_DUAL     = 4'h3;
    localparam logic [3:0] OE_QUAD     = 4'hF;
    localparam logic [2:0] CNT_RST     = 3'h0;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [2:0] GRP_SINGLE  = 3'h7;
    localparam logic [2:0] GRP_DUAL    = 3'h3;
    localparam logic [2:0] GRP_QUAD    = 3'h1;

    // deselect quiet time before no byte may still arrive, in sys cycles
    localparam int RX_SETTLE_CYC = 4;

    typedef enum logic [1:0] {
        LANE_SINGLE,
        LANE_DUAL,
        LANE_QUAD
    } sff_lane_mode_t;

    typedef enum logic [1:0] {
        ERASE_4K,
        ERASE_32K,
        ERASE_64K,
        ERASE_CHIP
    } sff_erase_kind_t;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_FRAME,
        ST_FINISH
    } sff_state_t;

    // pins of the four data lanes
    typedef struct packed {
        logic [3:0] dq;
        logic [3:0] oe;
    } sff_lanes_t;

endpackage

// ---- hw/sff_fifo.sv ----
`timescale 1ns/100ps
module sff_fifo
    import sff_pkg::*;
#(
    parameter int WIDTH = BYTE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output      logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output      logic             out_valid_o,
    input  wire logic             out_ready_i,
    output      logic [WIDTH-1:0] out_data_o
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("sff_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid_i && in_ready_o && ce_i;
    wire pop  = out_valid_o && out_ready_i && ce_i;

    assign in_ready_o  = (count < (AW + 1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

endmodule

// ---- hw/sff_front_end.sv ----
`timescale 1ns/100ps
module sff_front_end
    import sff_pkg::*;
(
    input  wire logic            CLK_I,
    input  wire logic            SYS_RST_I,
    input  wire logic            CE_I,
    input  wire logic            SCK_I,
    input  wire logic            CS_N_I,
    input  wire logic            HOLD_N_I,
    input  wire logic            SI_I,
    output      sff_lanes_t      LANES_O,
    input  wire sff_lane_mode_t  LANE_MODE_I,
    input  wire logic            BUSY_I,
    output      logic [7:0]      RX_DATA_O,
    output      logic            RX_VALID_O,
    input  wire logic            RX_READY_I,
    output      logic            RX_OVF_O,
    input  wire logic [7:0]      TX_DATA_I,
    input  wire logic            TX_VALID_I,
    output      logic            TX_READY_O,
    output      logic            FRAME_START_O,
    output      logic            FRAME_END_O,
    output      logic            STANDBY_O,
    input  wire logic            PROG_I,
    output      logic [8:0]      PROG_CNT_O,
    output      logic [7:0]      PROG_COL_O,
    input  wire sff_erase_kind_t ERASE_KIND_I,
    output      logic [ADDR_W-1:0] ERASE_MASK_O,
    input  wire logic [SEC_PAGES-1:0] SEC_LOCK_I,
    output      logic [SEC_PAGES-1:0] SEC_LOCKED_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // link side, rising edge: input shifter

    logic [6:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] rx_byte;
    logic       rx_tog;
    logic       lane0_out;

    wire rx_take  = HOLD_N_I && !lane0_out;
    wire rx_whole = rx_take && (rx_cnt == BIT_LAST);

    always_ff @(posedge SCK_I or posedge CS_N_I) begin
        if (CS_N_I) begin
            rx_sh  <= '0;
            rx_cnt <= CNT_RST;
        end else if (rx_take) begin
            rx_sh  <= {rx_sh[5:0], SI_I};
            rx_cnt <= rx_cnt + 3'h1;
        end
    end

    // modes 0 and 3
    // byte and toggle survive deselect so the last byte still crosses
    always_ff @(posedge SCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rx_byte <= BYTE_RST;
            rx_tog  <= 1'b0;
        end else if (rx_whole && !CS_N_I) begin
            rx_byte <= {rx_sh, SI_I};
            rx_tog  <= ~rx_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link side, falling edge: output shifter

    logic [7:0] tx_buf;
    logic       tx_tog;
    logic       tx_s1;
    logic       tx_s2;
    logic       tx_taken;
    logic [1:0] md_s1;
    logic [1:0] md_s2;
    logic [7:0] tx_sh;
    logic [2:0] grp_left;
    logic       driving;
    logic [3:0] out_q;

    wire sff_lane_mode_t link_mode = sff_lane_mode_t'(md_s2);
    wire tx_due    = (grp_left == CNT_RST);
    wire tx_load   = HOLD_N_I && tx_due && (tx_s2 != tx_taken);
    wire [7:0] src = tx_load ? tx_buf : tx_sh;
    wire [2:0] grp_n = (link_mode == LANE_QUAD) ? GRP_QUAD :
                       (link_mode == LANE_DUAL) ? GRP_DUAL : GRP_SINGLE;
    wire [3:0] grp_bits = (link_mode == LANE_QUAD) ? src[7:4] :
                          (link_mode == LANE_DUAL) ? {2'h0, src[7:6]} :
                          {2'h0, src[7], 1'b0};
    wire [7:0] src_rest = (link_mode == LANE_QUAD) ? {src[3:0], 4'h0} :
                          (link_mode == LANE_DUAL) ? {src[5:0], 2'h0} :
                          {src[6:0], 1'h0};
    wire [3:0] oe_mask  = (link_mode == LANE_QUAD) ? OE_QUAD :
                          (link_mode == LANE_DUAL) ? OE_DUAL : OE_SINGLE;

    // toggle and mode synchronisers, kept across frames
    always_ff @(negedge SCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tx_s1    <= 1'b0;
            tx_s2    <= 1'b0;
            md_s1    <= '0;
            md_s2    <= '0;
            tx_taken <= 1'b0;
        end else begin
            tx_s1 <= tx_tog;
            tx_s2 <= tx_s1;
            md_s1 <= LANE_MODE_I;
            md_s2 <= md_s1;
            if (tx_load && !CS_N_I) begin
                tx_taken <= ~tx_taken;
            end
        end
    end

    always_ff @(negedge SCK_I or posedge CS_N_I) begin
        if (CS_N_I) begin
            tx_sh    <= BYTE_RST;
            grp_left <= CNT_RST;
            driving  <= 1'b0;
            out_q    <= LANE_OFF;
        end else if (HOLD_N_I) begin
            if (tx_load || !tx_due) begin
                out_q    <= grp_bits;
                tx_sh    <= src_rest;
                grp_left <= tx_load ? grp_n : grp_left - 3'h1;
                driving  <= 1'b1;
            end else begin
                driving  <= 1'b0;
            end
        end
    end

    assign lane0_out = driving && (link_mode != LANE_SINGLE);

    assign LANES_O.oe = (driving && !CS_N_I && HOLD_N_I) ? oe_mask : LANE_OFF;
    assign LANES_O.dq = out_q;

    ////////////////////////////////////////////////////////////////////////////////
    // system side: crossings

    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic rs1;
    logic rs2;
    logic rs3;
    logic ts1;
    logic ts2;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            cs_s1 <= CS_IDLE;
            cs_s2 <= CS_IDLE;
            cs_d  <= CS_IDLE;
            rs1   <= 1'b0;
            rs2   <= 1'b0;
            rs3   <= 1'b0;
            ts1   <= 1'b0;
            ts2   <= 1'b0;
        end else if (CE_I) begin
            cs_s1 <= CS_N_I;
            cs_s2 <= cs_s1;
            cs_d  <= cs_s2;
            rs1   <= rx_tog;
            rs2   <= rs1;
            rs3   <= rs2;
            ts1   <= tx_taken;
            ts2   <= ts1;
        end
    end

    wire frame_rise = cs_s2 && !cs_d;
    wire frame_fall = !cs_s2 && cs_d;
    wire rx_new     = rs2 ^ rs3;

    ////////////////////////////////////////////////////////////////////////////////
    // receive path into the fifo

    logic [7:0] rx_hold;
    logic       rx_pend;
    logic       fifo_ready;

    // stall: a byte waits in rx_hold while the fifo is full
    wire rx_push = rx_pend && fifo_ready;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            rx_hold  <= BYTE_RST;
            rx_pend  <= 1'b0;
            RX_OVF_O <= 1'b0;
        end else if (CE_I) begin
            if (rx_new) begin
                rx_hold <= rx_byte;
            end
            rx_pend <= rx_new || (rx_pend && !fifo_ready);
            // overflow set wins over frame-start clear
            RX_OVF_O <= (rx_new && rx_pend && !fifo_ready) || (RX_OVF_O && !frame_fall);
        end
    end

    sff_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (CLK_I),
        .rst_i       (SYS_RST_I),
        .ce_i        (CE_I),
        .in_valid_i  (rx_pend),
        .in_ready_o  (fifo_ready),
        .in_data_i   (rx_hold),
        .out_valid_o (RX_VALID_O),
        .out_ready_i (RX_READY_I),
        .out_data_o  (RX_DATA_O)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // transmit handover; tx_buf only moves while the link has taken it

    assign TX_READY_O = (tx_tog == ts2);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            tx_buf <= BYTE_RST;
            tx_tog <= 1'b0;
        end else if (CE_I) begin
            if (TX_VALID_I && TX_READY_O) begin
                tx_buf <= TX_DATA_I;
                tx_tog <= ~tx_tog;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame state

    sff_state_t state;
    sff_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            ST_STANDBY: begin
                if (frame_fall) next_state = ST_FRAME;
            end
            ST_FRAME: begin
                if (frame_rise) next_state = BUSY_I ? ST_FINISH : ST_STANDBY;
            end
            ST_FINISH: begin
                if (frame_fall) next_state = ST_FRAME;
                else if (!BUSY_I) next_state = ST_STANDBY;
            end
            default: next_state = ST_STANDBY;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state         <= ST_STANDBY;
            FRAME_START_O <= 1'b0;
            FRAME_END_O   <= 1'b0;
        end else if (CE_I) begin
            state         <= next_state;
            FRAME_START_O <= frame_fall;
            FRAME_END_O   <= frame_rise;
        end
    end

    assign STANDBY_O = (state == ST_STANDBY);

    ////////////////////////////////////////////////////////////////////////////////
    // program count, erase span, security locks

    wire prog_take = PROG_I && rx_push && (PROG_CNT_O != 9'(PAGE_BYTES));
    wire [ADDR_W-1:0] next_mask =
        (ERASE_KIND_I == ERASE_4K)  ? ADDR_W'(ERASE_4K_BYTES - 1) :
        (ERASE_KIND_I == ERASE_32K) ? ADDR_W'(ERASE_32K_BYTES - 1) :
        (ERASE_KIND_I == ERASE_64K) ? ADDR_W'(ERASE_64K_BYTES - 1) : '1;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            PROG_CNT_O   <= '0;
            PROG_COL_O   <= '0;
            ERASE_MASK_O <= '0;
        end else if (CE_I) begin
            if (frame_fall) begin
                PROG_CNT_O <= '0;
                PROG_COL_O <= '0;
            end else if (prog_take) begin
                PROG_CNT_O <= PROG_CNT_O + 9'h001;
                // column wraps inside the page
                PROG_COL_O <= PROG_COL_O + 8'h01;
            end
            ERASE_MASK_O <= next_mask;
        end
    end

    // locks only ever set; reset is the sole clear
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            SEC_LOCKED_O <= '0;
        end else if (CE_I) begin
            SEC_LOCKED_O <= SEC_LOCKED_O | SEC_LOCK_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    AST_OE_OFF_DESELECT: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I) CS_N_I |-> (LANES_O.oe == LANE_OFF))
        else $error("lanes driven while deselected");

    AST_STANDBY_AFTER_END: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (CE_I && state == ST_FRAME && frame_rise && !BUSY_I) |=> STANDBY_O)
        else $error("no standby after idle deselect");

    AST_NO_RX_DESELECTED: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I) (cs_s2 && CE_I) [*4] |=> !rx_new)
        else $error("byte arrived while deselected");

    AST_FRAME_START: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (CE_I && cs_d && !cs_s2) |=> FRAME_START_O ##1 (!FRAME_START_O || !CE_I))
        else $error("frame start pulse missing");

    AST_BUSY_NO_STANDBY: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (CE_I && state == ST_FINISH && BUSY_I) |=> !STANDBY_O)
        else $error("standby while cycle runs");

    AST_RISE_SAMPLE: assert property (
        @(posedge SCK_I) disable iff (CS_N_I || SYS_RST_I)
        rx_whole |=> (rx_byte[0] == $past(SI_I)))
        else $error("input bit not taken at rising edge");

    AST_FALL_LOAD: assert property (
        @(negedge SCK_I) disable iff (CS_N_I || SYS_RST_I)
        (tx_load && link_mode == LANE_QUAD) |=> (out_q == $past(tx_buf[7:4])))
        else $error("first nibble not driven at falling edge");

    AST_LANE0_MODE: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        LANES_O.oe[0] |-> (link_mode != LANE_SINGLE))
        else $error("lane zero driven in single mode");

    AST_PAGE_LIMIT: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I) PROG_CNT_O <= 9'(PAGE_BYTES))
        else $error("program count past one page");

    AST_ERASE_4K: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (CE_I && ERASE_KIND_I == ERASE_4K) |=> (ERASE_MASK_O == 22'h000FFF))
        else $error("wrong 4K erase mask");

    AST_LOCK_STICKY: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (CE_I && SEC_LOCK_I != '0) |=> ((SEC_LOCKED_O & $past(SEC_LOCK_I)) == $past(SEC_LOCK_I)))
        else $error("security lock not set");

    AST_PAUSE_TRISTATE: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I) !HOLD_N_I |-> (LANES_O.oe == LANE_OFF))
        else $error("lanes driven during pause");

    COV_FRAME: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) FRAME_END_O);
    COV_FINISH: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) state == ST_FINISH);
    COV_QUAD: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) LANES_O.oe == OE_QUAD);
    COV_FULL: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) rx_pend && !fifo_ready);

endmodule

// ---- bench/sff_host_model.sv ----
`timescale 1ns/100ps
module sff_host_model
    import sff_pkg::*;
(
    output logic            sck_o,
    output logic            cs_n_o,
    output logic            hold_n_o,
    output logic            si_o,
    input  wire sff_lanes_t lanes_i
);
    localparam time HALF = 40;
    logic       cpol     = 1'b0;
    logic [7:0] acc      = BYTE_RST;
    logic [3:0] oe       = LANE_OFF;
    logic [3:0] last_oe  = LANE_OFF;
    int         nbits    = 0;
    int         w        = 1;
    int         edge_err = 0;
    logic [7:0] out_q[$];

    initial begin
        sck_o    = 1'b0;
        cs_n_o   = CS_IDLE;
        hold_n_o = 1'b1;
        si_o     = 1'b0;
    end
    ////////////////////////////////////////
    // read lane groups on rises; lanes must be off while paused
    always @(posedge sck_o) begin
        oe = lanes_i.oe;
        if (!hold_n_o && oe != LANE_OFF) begin
            edge_err++;
        end
        if (!cs_n_o && hold_n_o && oe != LANE_OFF) begin
            last_oe = oe;
            w       = (oe == OE_QUAD) ? 4 : (oe == OE_DUAL) ? 2 : 1;
            acc     = (acc << w) |
                      ((oe == OE_SINGLE) ? 4'(lanes_i.dq[1]) : (lanes_i.dq & oe));
            nbits   = nbits + w;
            if (nbits >= 8) begin
                out_q.push_back(acc);
                nbits = 0;
            end
        end
    end

    // lanes may only move on a fall
    always @(lanes_i.dq) begin
        if (!cs_n_o && sck_o) begin
            edge_err++;
        end
    end
    ////////////////////////////////////////
    // falling select opens the frame
    task automatic select();
        #3.3;
        sck_o = cpol;
        #HALF;
        cs_n_o = 1'b0;
        #HALF;
    endtask

    task automatic send(input logic [7:0] b, input int pause_at);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            if (i == pause_at) begin
                #10;
                hold_n_o = 1'b0;
                repeat (4) begin
                    #HALF;
                    sck_o = ~sck_o;
                    si_o  = ~si_o;
                end
                #HALF;
                hold_n_o = 1'b1;
            end
            si_o = b[i];
            #HALF;
            sck_o = 1'b1;
            #HALF;
        end
    endtask

    // rising select ends frame, line let go
    task automatic deselect();
        if (!cpol) begin
            sck_o = 1'b0;
        end
        #(2 * HALF);
        cs_n_o = CS_IDLE;
        si_o   = ~si_o;
        nbits  = 0;
        #HALF;
    endtask
endmodule

// ---- bench/serial_flash_spi_front_end_bench.sv ----
`timescale 1ns/100ps
`define CHK(a, e) \
    begin \
        total_checks++; \
        if ((a) !== (e)) begin \
            miscompares++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); \
        end \
    end

module serial_flash_spi_front_end_bench
    import sff_pkg::*;
    ;
    logic                 clk        = 1'b0;
    logic                 rst        = 1'b1;
    logic                 ce         = 1'b1;
    logic                 busy       = 1'b0;
    logic                 rx_ready   = 1'b0;
    logic                 tx_valid   = 1'b0;
    logic                 prog       = 1'b0;
    logic [7:0]           tx_data    = BYTE_RST;
    logic [SEC_PAGES-1:0] sec_lock   = 3'h0;
    sff_lane_mode_t       lane_mode  = LANE_SINGLE;
    sff_erase_kind_t      erase_kind = ERASE_4K;
    logic                 sck, cs_n, hold_n, si_h;
    logic                 rx_valid, rx_ovf, tx_ready, f_start, f_end, standby;
    wire logic            si_w;
    sff_lanes_t           lanes;
    logic [7:0]           rx_data, prog_col;
    logic [8:0]           prog_cnt;
    logic [ADDR_W-1:0]    erase_mask;
    logic [SEC_PAGES-1:0] sec_locked;
    int                   miscompares = 0, total_checks = 0, n_start = 0, n_end = 0;

    // lane zero: the device wins while it drives
    assign si_w = lanes.oe[0] ? lanes.dq[0] : si_h;

    sff_front_end u_sff_front_end (
        .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .SCK_I(sck), .CS_N_I(cs_n),
        .HOLD_N_I(hold_n), .SI_I(si_w), .LANES_O(lanes), .LANE_MODE_I(lane_mode),
        .BUSY_I(busy), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
        .RX_READY_I(rx_ready), .RX_OVF_O(rx_ovf), .TX_DATA_I(tx_data),
        .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .FRAME_START_O(f_start),
        .FRAME_END_O(f_end), .STANDBY_O(standby), .PROG_I(prog),
        .PROG_CNT_O(prog_cnt), .PROG_COL_O(prog_col), .ERASE_KIND_I(erase_kind),
        .ERASE_MASK_O(erase_mask), .SEC_LOCK_I(sec_lock), .SEC_LOCKED_O(sec_locked)
    );
    sff_host_model u_sff_host_model (
        .sck_o(sck), .cs_n_o(cs_n), .hold_n_o(hold_n), .si_o(si_h), .lanes_i(lanes)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        n_start <= n_start + (f_start === 1'b1);
        n_end   <= n_end + (f_end === 1'b1);
    end
    ////////////////////////////////////////
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pop(input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clk);
        while (rx_valid !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        `CHK(rx_valid, 1'b1)
        `CHK(rx_data, e)
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask

    // bytes nobody checks are drained unseen
    task automatic flush();
        @(posedge clk);
        rx_ready <= 1'b1;
        cyc(20);
        rx_ready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic tx_push(input logic [7:0] b);
        int n;
        n = 0;
        tx_data  <= b;
        tx_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 2000);
    endtask

    task automatic frame(input int n, input logic [7:0] b0);
        u_sff_host_model.select();
        for (int i = 0; i < n; i++) begin
            u_sff_host_model.send(b0 + 8'(i), -1);
        end
        u_sff_host_model.deselect();
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        @(posedge clk);
        `CHK(standby, 1'b1)
        `CHK(lanes.oe, LANE_OFF)
        `CHK(rx_valid, 1'b0)
        `CHK(tx_ready, 1'b1)
        $display("test reset done");
    endtask

    task automatic t_rx(input logic mode3);
        int s0;
        int e0;
        s0 = n_start;
        e0 = n_end;
        u_sff_host_model.cpol = mode3;
        fork
            frame(2, 8'hC1);
            begin
                cyc(20);
                `CHK(standby, 1'b0)
            end
        join
        cyc(10);
        `CHK(n_start, s0 + 1)
        `CHK(n_end, e0 + 1)
        `CHK(standby, 1'b1)
        `CHK(lanes.oe, LANE_OFF)
        pop(8'hC1);
        pop(8'hC2);
        $display("test rx done");
    endtask

    task automatic t_hold();
        int s0;
        s0 = n_start;
        // clocking with select high must be ignored
        u_sff_host_model.send(8'h3C, -1);
        cyc(20);
        `CHK(rx_valid, 1'b0)
        `CHK(n_start, s0)
        busy <= 1'b1;
        u_sff_host_model.select();
        u_sff_host_model.send(8'h96, 3);
        u_sff_host_model.deselect();
        cyc(30);
        `CHK(standby, 1'b0)
        `CHK(u_sff_host_model.edge_err, 0)
        busy <= 1'b0;
        cyc(5);
        `CHK(standby, 1'b1)
        pop(8'h96);
        $display("test hold done");
    endtask

    task automatic t_ovf();
        frame(10, 8'h10);
        cyc(10);
        `CHK(rx_ovf, 1'b1)
        for (int i = 0; i < 8; i++) begin
            pop(8'h10 + 8'(i));
        end
        // newest byte overwrites the one held back
        pop(8'h19);
        cyc(5);
        `CHK(rx_valid, 1'b0)
        $display("test overflow done");
    endtask

    task automatic t_prog();
        @(posedge clk);
        prog     <= 1'b1;
        rx_ready <= 1'b1;
        fork
            frame(258, 8'h00);
            begin
                cyc(150);
                `CHK(rx_ovf, 1'b0)
            end
        join
        cyc(10);
        `CHK(prog_cnt, 9'h100)
        `CHK(prog_col, 8'h00)
        prog     <= 1'b0;
        rx_ready <= 1'b0;
        $display("test program done");
    endtask

    task automatic t_misc();
        int span[4];
        span = '{ERASE_4K_BYTES, ERASE_32K_BYTES, ERASE_64K_BYTES, 1 << ADDR_W};
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            erase_kind <= sff_erase_kind_t'(k);
            cyc(3);
            `CHK(erase_mask, ADDR_W'(span[k] - 1))
        end
        sec_lock <= 3'h2;
        @(posedge clk);
        sec_lock <= 3'h0;
        cyc(3);
        `CHK(sec_locked, 3'h2)
        sec_lock <= 3'h1;
        @(posedge clk);
        sec_lock <= 3'h0;
        cyc(3);
        `CHK(sec_locked, 3'h3)
        // clock enable low freezes the lock register
        ce       <= 1'b0;
        sec_lock <= 3'h4;
        @(posedge clk);
        sec_lock <= 3'h0;
        cyc(2);
        `CHK(sec_locked, 3'h3)
        ce <= 1'b1;
        cyc(2);
        $display("test erase lock done");
    endtask

    // a short frame first lets the new lane mode settle
    task automatic t_tx(input sff_lane_mode_t m, input logic [3:0] oe_exp);
        @(posedge clk);
        lane_mode <= m;
        frame(1, 8'hFF);
        flush();
        u_sff_host_model.out_q.delete();
        fork
            frame(4, 8'h00);
            begin
                tx_push(8'hB4);
                tx_push(8'h69);
                tx_valid <= 1'b0;
            end
        join
        cyc(10);
        `CHK(u_sff_host_model.out_q.size(), 2)
        `CHK(u_sff_host_model.out_q[0], 8'hB4)
        `CHK(u_sff_host_model.out_q[1], 8'h69)
        `CHK(u_sff_host_model.last_oe, oe_exp)
        `CHK(u_sff_host_model.edge_err, 0)
        `CHK(lanes.oe, LANE_OFF)
        flush();
        $display("test transmit done");
    endtask
    ////////////////////////////////////////
    initial begin
        #600_000;
        miscompares++;
        end_sim();
    end

    initial begin
        cyc(20);
        rst <= 1'b0;
        t_reset();
        t_rx(1'b0);
        t_rx(1'b1);
        t_hold();
        t_ovf();
        t_prog();
        t_misc();
        t_tx(LANE_SINGLE, OE_SINGLE);
        t_tx(LANE_DUAL, OE_DUAL);
        t_tx(LANE_QUAD, OE_QUAD);
        end_sim();
    end
endmodule
